/* File: rtl/cache_op_permission_check.sv */
// Purpose: privilege checks for cache-block operations
// Assumes: request and csr port on the core clock
// Notes:   answer one cycle after the request
//
// Summary of operation
// RL1: invalidate-enable field in bits 5:4; 00 trap, 01 flush, 11 invalidate.
// RL2: invalidate runs as true invalidate when no applicable field picks flush.
// RL3: bit 6 enables clean and flush below machine mode.
// RL4: bit 7 enables block-zero below machine mode.
// RL5: invalidate illegal if machine field 00 off-M, or supervisor field 00 in U.
// RL6: otherwise virtual fault in VS with hyp field 00, or VU with either 00.
// RL7: executing invalidate flushes when an applicable field reads 01.
// RL8: clean/flush illegal if machine bit clear off-M, supervisor clear in U.
// RL9: otherwise virtual fault in VS if hyp clear, VU unless both set.
// RL10: zero illegal if machine bit clear off-M, supervisor clear in U.
// RL11: otherwise virtual fault in VS if hyp clear, VU unless both set.
// RL12: illegal checked first, then virtual, execute only when neither.
// RL13: one supervisor register serves all supervisor modes.
// RL14: hypervisor register exists and counts only with hypervisor on.
// RL15: block sizes and invalidate support are visible to software.
// RL16: software should learn legal values from discovery, not by probing.
// RL17: higher levels clean blocks before granting true invalidates.
// RL18: reserved invalidate encoding writes keep the old value.
`timescale 1ns/1ps
`default_nettype none
module cache_op_permission_check #(
   parameter int         MGMT_BLK_LOG2 = 6,
   parameter int         ZERO_BLK_LOG2 = 6,
   parameter logic [2:0] INV_SUPPORT   = 3'h7
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        hyp_on,
   input  wire logic        csr_we,
   input  wire logic [1:0]  csr_sel,
   input  wire logic [63:0] csr_wdata,
   output var  logic [63:0] csr_rdata,
   input  wire logic        req_valid,
   input  wire logic [1:0]  req_op,
   input  wire logic [2:0]  req_priv,
   output var  logic        rsp_valid,
   output var  logic        rsp_illegal,
   output var  logic        rsp_virtual,
   output var  logic        rsp_exec,
   output var  logic        rsp_flush,
   output var  logic [7:0]  disc_mgmt_blk,
   output var  logic [7:0]  disc_zero_blk,
   output var  logic [2:0]  disc_inv_ok
);
   cmo_perm_pkg::env_cfg_t cfg_q [3];
   cmo_perm_pkg::env_cfg_t rd_cfg;
   logic [63:0]            rdata_d;
   logic                   rd_hidden;
   cmo_decide_if           dif ();

   // one register per privilege level, indexed by select code
   for (genvar i = 0; i < 3; i++) begin : g_cfg
      logic                   hit;
      cmo_perm_pkg::env_cfg_t wr;
      // RL14 hyp writes dropped when absent
      assign hit = ce && csr_we && (csr_sel == 2'(i)) &&
                   ((2'(i) != cmo_perm_pkg::SEL_H) || hyp_on);
      // RL3 clean-flush at bit 6
      assign wr.clean_flush_enable_bit =
         csr_wdata[cmo_perm_pkg::CF_BIT];
      // RL4 zero at bit 7
      assign wr.zero_enable_bit = csr_wdata[cmo_perm_pkg::ZE_BIT];
      // RL18 reserved write legalised
      assign wr.invalidate_enable_field =
         (csr_wdata[cmo_perm_pkg::INV_HI:cmo_perm_pkg::INV_LO] ==
          cmo_perm_pkg::INV_RSV) ?
         cfg_q[i].invalidate_enable_field :
         csr_wdata[cmo_perm_pkg::INV_HI:cmo_perm_pkg::INV_LO];
      // RL1 field storage
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            cfg_q[i] <= cmo_perm_pkg::CFG_RST;
         end else if (hit) begin
            cfg_q[i] <= wr;
         end
      end
   end

   // read mux; the hyp register reads zero while it does not exist
   assign rd_hidden = (csr_sel == cmo_perm_pkg::SEL_H) && !hyp_on;
   always_comb begin
      rd_cfg  = cmo_perm_pkg::CFG_RST;
      rdata_d = 64'h0000_0000_0000_0000;
      if (csr_sel <= cmo_perm_pkg::SEL_H && !rd_hidden) begin
         rd_cfg = cfg_q[csr_sel];
      end
      rdata_d[cmo_perm_pkg::INV_HI:cmo_perm_pkg::INV_LO] =
         rd_cfg.invalidate_enable_field;
      rdata_d[cmo_perm_pkg::CF_BIT] = rd_cfg.clean_flush_enable_bit;
      rdata_d[cmo_perm_pkg::ZE_BIT] = rd_cfg.zero_enable_bit;
   end

   // registered read data, valid the cycle after the select
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         csr_rdata <= 64'h0000_0000_0000_0000;
      end else if (ce) begin
         csr_rdata <= rdata_d;
      end
   end

   // feed the decision logic
   assign dif.m_cfg  = cfg_q[cmo_perm_pkg::SEL_M];
   // RL13 same copy for S, VS, VU
   assign dif.s_cfg  = cfg_q[cmo_perm_pkg::SEL_S];
   // RL14 absent hyp fields read as zero
   assign dif.h_cfg  = hyp_on ? cfg_q[cmo_perm_pkg::SEL_H] :
                                cmo_perm_pkg::CFG_RST;
   assign dif.hyp_on = hyp_on;
   assign dif.op     = req_op;
   assign dif.priv   = req_priv;

   cmo_decide u_decide (
      .dif (dif)
   );

   // answer register; results are masked when no request came
   // RL12 one outcome per request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid   <= 1'b0;
         rsp_illegal <= 1'b0;
         rsp_virtual <= 1'b0;
         rsp_exec    <= 1'b0;
         rsp_flush   <= 1'b0;
      end else if (ce) begin
         rsp_valid   <= req_valid;
         rsp_illegal <= req_valid && dif.illegal;
         rsp_virtual <= req_valid && dif.virt;
         rsp_exec    <= req_valid && dif.exec;
         rsp_flush   <= req_valid && dif.flush;
      end
   end

   // RL15 discovery outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         disc_mgmt_blk <= 8'h00;
         disc_zero_blk <= 8'h00;
         disc_inv_ok   <= 3'h0;
      end else if (ce) begin
         disc_mgmt_blk <= 8'(MGMT_BLK_LOG2);
         disc_zero_blk <= 8'(ZERO_BLK_LOG2);
         disc_inv_ok   <= INV_SUPPORT;
      end
   end

   // checks on the design's own outputs and state
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   logic       go;
   logic       inv;
   logic [1:0] m_i;
   logic [1:0] s_i;
   logic [1:0] h_i;
   assign go  = ce && req_valid;
   assign inv = (req_op == cmo_perm_pkg::OP_INVAL);
   assign m_i = cfg_q[0].invalidate_enable_field;
   assign s_i = cfg_q[1].invalidate_enable_field;
   assign h_i = cfg_q[2].invalidate_enable_field;

   property p_no_rsv;
      (ce && csr_we) |=> (m_i != cmo_perm_pkg::INV_RSV) &&
         (s_i != cmo_perm_pkg::INV_RSV) &&
         (h_i != cmo_perm_pkg::INV_RSV);
   endproperty
   a_no_rsv: assert property (p_no_rsv) // RL18
      else $error("reserved invalidate encoding stored");

   property p_inv_ill;
      (go && inv && req_priv != cmo_perm_pkg::PRV_M &&
       m_i == cmo_perm_pkg::INV_TRAP) |=> rsp_illegal && !rsp_exec;
   endproperty
   a_inv_ill: assert property (p_inv_ill) // RL5
      else $error("invalidate not trapped by machine field");

   property p_inv_virt;
      (go && inv && hyp_on && req_priv == cmo_perm_pkg::PRV_VS &&
       m_i != cmo_perm_pkg::INV_TRAP &&
       h_i == cmo_perm_pkg::INV_TRAP) |=> rsp_virtual && !rsp_illegal;
   endproperty
   a_inv_virt: assert property (p_inv_virt) // RL6
      else $error("invalidate in VS missed virtual fault");

   property p_inv_flush;
      (go && inv && req_priv == cmo_perm_pkg::PRV_S &&
       m_i == cmo_perm_pkg::INV_FLUSH) |=> rsp_exec && rsp_flush;
   endproperty
   a_inv_flush: assert property (p_inv_flush) // RL7
      else $error("invalidate not demoted to flush");

   property p_inv_true;
      (go && inv && req_priv == cmo_perm_pkg::PRV_M) |=>
         rsp_exec && !rsp_flush;
   endproperty
   a_inv_true: assert property (p_inv_true) // RL2
      else $error("machine invalidate not a true invalidate");

   property p_cf_ill;
      (go && req_op == cmo_perm_pkg::OP_CLEAN &&
       req_priv == cmo_perm_pkg::PRV_U &&
       !cfg_q[1].clean_flush_enable_bit) |=> rsp_illegal;
   endproperty
   a_cf_ill: assert property (p_cf_ill) // RL8
      else $error("user clean not trapped");

   property p_cf_virt;
      (go && req_op == cmo_perm_pkg::OP_FLUSH && hyp_on &&
       req_priv == cmo_perm_pkg::PRV_VU &&
       cfg_q[0].clean_flush_enable_bit &&
       !cfg_q[2].clean_flush_enable_bit) |=> rsp_virtual;
   endproperty
   a_cf_virt: assert property (p_cf_virt) // RL9
      else $error("VU flush missed virtual fault");

   property p_ze_ill;
      (go && req_op == cmo_perm_pkg::OP_ZERO &&
       req_priv == cmo_perm_pkg::PRV_S &&
       !cfg_q[0].zero_enable_bit) |=> rsp_illegal;
   endproperty
   a_ze_ill: assert property (p_ze_ill) // RL10
      else $error("supervisor zero not trapped");

   property p_ze_virt;
      (go && req_op == cmo_perm_pkg::OP_ZERO && hyp_on &&
       req_priv == cmo_perm_pkg::PRV_VS &&
       cfg_q[0].zero_enable_bit &&
       !cfg_q[2].zero_enable_bit) |=> rsp_virtual && !rsp_exec;
   endproperty
   a_ze_virt: assert property (p_ze_virt) // RL11
      else $error("VS zero missed virtual fault");

   property p_one_hot;
      rsp_valid |-> $onehot({rsp_illegal, rsp_virtual, rsp_exec});
   endproperty
   a_one_hot: assert property (p_one_hot) // RL12
      else $error("response not exactly one outcome");

   property p_no_hyp;
      (go && !hyp_on) |=> !rsp_virtual;
   endproperty
   a_no_hyp: assert property (p_no_hyp) // RL14
      else $error("virtual fault with hypervisor off");

   // a stray outcome between requests would be taken as a trap downstream
   property p_rsp_idle;
      !rsp_valid |-> !(rsp_illegal || rsp_virtual || rsp_exec || rsp_flush);
   endproperty
   a_rsp_idle: assert property (p_rsp_idle) // RL12
      else $error("outcome raised without a request");

   // a low clock enable must hold the answer and the stored fields
   property p_freeze_rsp;
      !ce |=> $stable({rsp_valid, rsp_illegal, rsp_virtual, rsp_exec, rsp_flush});
   endproperty
   a_freeze_rsp: assert property (p_freeze_rsp) // RL12
      else $error("answer moved while clock enable low");

   property p_freeze_cfg;
      !ce |=> $stable(cfg_q[0]) && $stable(cfg_q[1]) && $stable(cfg_q[2]);
   endproperty
   a_freeze_cfg: assert property (p_freeze_cfg) // RL1
      else $error("fields moved while clock enable low");

   // a legal write lands in the selected register
   property p_wr_land;
      (ce && csr_we && csr_sel == cmo_perm_pkg::SEL_S &&
       csr_wdata[cmo_perm_pkg::INV_HI:cmo_perm_pkg::INV_LO] != cmo_perm_pkg::INV_RSV) |=>
         s_i == $past(csr_wdata[cmo_perm_pkg::INV_HI:cmo_perm_pkg::INV_LO]);
   endproperty
   a_wr_land: assert property (p_wr_land) // RL1
      else $error("supervisor invalidate field not written");

   property p_rsv_keep;
      (ce && csr_we && csr_sel == cmo_perm_pkg::SEL_M &&
       csr_wdata[cmo_perm_pkg::INV_HI:cmo_perm_pkg::INV_LO] == cmo_perm_pkg::INV_RSV) |=>
         $stable(m_i);
   endproperty
   a_rsv_keep: assert property (p_rsv_keep) // RL18
      else $error("reserved write changed the machine field");

   // readback layout: fields in bits 7:4, every other bit zero
   property p_rd_sup;
      (ce && csr_sel == cmo_perm_pkg::SEL_S) |=>
         csr_rdata == {56'h00_0000_0000_0000, $past(cfg_q[1]), 4'h0};
   endproperty
   a_rd_sup: assert property (p_rd_sup) // RL1
      else $error("supervisor readback wrong");

   property p_rd_cf;
      (ce && csr_sel == cmo_perm_pkg::SEL_M) |=>
         csr_rdata[cmo_perm_pkg::CF_BIT] == $past(cfg_q[0].clean_flush_enable_bit);
   endproperty
   a_rd_cf: assert property (p_rd_cf) // RL3
      else $error("clean-flush enable not at its bit");

   // the hypervisor register is hidden and locked while absent
   property p_hyp_hide;
      (ce && csr_sel == cmo_perm_pkg::SEL_H && !hyp_on) |=> csr_rdata == 64'h0000_0000_0000_0000;
   endproperty
   a_hyp_hide: assert property (p_hyp_hide) // RL14
      else $error("absent hypervisor register readable");

   property p_hyp_lock;
      (ce && csr_we && csr_sel == cmo_perm_pkg::SEL_H && !hyp_on) |=> $stable(cfg_q[2]);
   endproperty
   a_hyp_lock: assert property (p_hyp_lock) // RL14
      else $error("absent hypervisor register written");

   // VU sees the supervisor field as well as the hypervisor one
   property p_inv_vu;
      (go && inv && hyp_on && req_priv == cmo_perm_pkg::PRV_VU &&
       m_i != cmo_perm_pkg::INV_TRAP && s_i == cmo_perm_pkg::INV_TRAP) |=> rsp_virtual;
   endproperty
   a_inv_vu: assert property (p_inv_vu) // RL6
      else $error("invalidate in VU missed virtual fault");

   property p_inv_vu_fl;
      (go && inv && hyp_on && req_priv == cmo_perm_pkg::PRV_VU && m_i == cmo_perm_pkg::INV_TRUE &&
       s_i == cmo_perm_pkg::INV_TRUE && h_i == cmo_perm_pkg::INV_FLUSH) |=> rsp_exec && rsp_flush;
   endproperty
   a_inv_vu_fl: assert property (p_inv_vu_fl) // RL7
      else $error("VU invalidate not demoted by hypervisor field");

   property p_cf_vs;
      (go && req_op == cmo_perm_pkg::OP_CLEAN && hyp_on && req_priv == cmo_perm_pkg::PRV_VS &&
       cfg_q[0].clean_flush_enable_bit && !cfg_q[2].clean_flush_enable_bit) |=> rsp_virtual;
   endproperty
   a_cf_vs: assert property (p_cf_vs) // RL9
      else $error("VS clean missed virtual fault");

   // discovery values stand from the first enabled edge on
   property p_disc;
      ce |=> disc_mgmt_blk == 8'(MGMT_BLK_LOG2) && disc_zero_blk == 8'(ZERO_BLK_LOG2) &&
         disc_inv_ok == INV_SUPPORT;
   endproperty
   a_disc: assert property (p_disc) // RL15
      else $error("discovery outputs wrong");

   cover property (rsp_valid && rsp_flush);
   cover property (rsp_valid && rsp_virtual);
   cover property (rsp_valid && rsp_exec && !rsp_flush);
   cover property (rsp_valid && rsp_illegal);
endmodule : cache_op_permission_check
`default_nettype wire

/* File: rtl/cmo_perm_pkg.sv */
// Purpose: constants for cache-op permission checking
// Assumes: 64-bit env-config registers, fields in low byte
// Notes:   privilege codes are local to this block
package cmo_perm_pkg;
   // env-config field positions
   localparam int INV_LO = 4;
   localparam int INV_HI = 5;
   localparam int CF_BIT = 6;
   localparam int ZE_BIT = 7;
   localparam int XLEN   = 64;
   // invalidate-enable encodings
   localparam logic [1:0] INV_TRAP  = 2'h0;
   localparam logic [1:0] INV_FLUSH = 2'h1;
   localparam logic [1:0] INV_RSV   = 2'h2;
   localparam logic [1:0] INV_TRUE  = 2'h3;
   // register select codes on the csr port
   localparam logic [1:0] SEL_M = 2'h0;
   localparam logic [1:0] SEL_S = 2'h1;
   localparam logic [1:0] SEL_H = 2'h2;
   // operation codes
   localparam logic [1:0] OP_CLEAN = 2'h0;
   localparam logic [1:0] OP_FLUSH = 2'h1;
   localparam logic [1:0] OP_INVAL = 2'h2;
   localparam logic [1:0] OP_ZERO  = 2'h3;
   // privilege codes
   localparam logic [2:0] PRV_U  = 3'h0;
   localparam logic [2:0] PRV_S  = 3'h1;
   localparam logic [2:0] PRV_M  = 3'h3;
   localparam logic [2:0] PRV_VU = 3'h4;
   localparam logic [2:0] PRV_VS = 3'h5;
   // field values after reset: everything traps
   localparam logic [3:0] CFG_RST = 4'h0;
   // stored fields of one env-config register
   typedef struct packed {
      logic       zero_enable_bit;
      logic       clean_flush_enable_bit;
      logic [1:0] invalidate_enable_field;
   } env_cfg_t;
endpackage : cmo_perm_pkg

/* File: rtl/cmo_decide_if.sv */
// Purpose: carrier between register block and decision logic
// Assumes: purely combinational path
// Notes:   one instance per checker
`timescale 1ns/1ps
`default_nettype none
interface cmo_decide_if;
   cmo_perm_pkg::env_cfg_t m_cfg;
   cmo_perm_pkg::env_cfg_t s_cfg;
   cmo_perm_pkg::env_cfg_t h_cfg;
   logic                   hyp_on;
   logic [1:0]             op;
   logic [2:0]             priv;
   logic                   illegal;
   logic                   virt;
   logic                   exec;
   logic                   flush;
   modport owner (output m_cfg, s_cfg, h_cfg, hyp_on, op, priv,
                  input illegal, virt, exec, flush);
   modport check (input m_cfg, s_cfg, h_cfg, hyp_on, op, priv,
                  output illegal, virt, exec, flush);
endinterface : cmo_decide_if
`default_nettype wire

/* File: rtl/cmo_decide.sv */
// Purpose: permission decision for one cache-block operation
// Assumes: inputs stable within the cycle
// Notes:   pure logic, registered by the caller
`timescale 1ns/1ps
`default_nettype none
module cmo_decide (
   cmo_decide_if.check dif
);
   logic       is_m;
   logic       is_u;
   logic       is_vs;
   logic       is_vu;
   logic [1:0] m_inv;
   logic [1:0] s_inv;
   logic [1:0] h_inv;
   logic       m_en;
   logic       s_en;
   logic       h_en;
   logic       ill;
   logic       vir;

   // mode decode; virtual modes only exist with the hypervisor on
   assign is_m  = (dif.priv == cmo_perm_pkg::PRV_M);
   assign is_u  = (dif.priv == cmo_perm_pkg::PRV_U);
   // RL14 hypervisor gating
   assign is_vs = dif.hyp_on && (dif.priv == cmo_perm_pkg::PRV_VS);
   assign is_vu = dif.hyp_on && (dif.priv == cmo_perm_pkg::PRV_VU);

   // RL13 shared supervisor copy
   assign m_inv = dif.m_cfg.invalidate_enable_field;
   assign s_inv = dif.s_cfg.invalidate_enable_field;
   assign h_inv = dif.h_cfg.invalidate_enable_field;

   // per-op enable bit of each level
   always_comb begin
      m_en = dif.m_cfg.clean_flush_enable_bit;
      s_en = dif.s_cfg.clean_flush_enable_bit;
      h_en = dif.h_cfg.clean_flush_enable_bit;
      if (dif.op == cmo_perm_pkg::OP_ZERO) begin
         m_en = dif.m_cfg.zero_enable_bit;
         s_en = dif.s_cfg.zero_enable_bit;
         h_en = dif.h_cfg.zero_enable_bit;
      end
      if (dif.op == cmo_perm_pkg::OP_INVAL) begin
         m_en = (m_inv != cmo_perm_pkg::INV_TRAP);
         s_en = (s_inv != cmo_perm_pkg::INV_TRAP);
         h_en = (h_inv != cmo_perm_pkg::INV_TRAP);
      end
   end

   // RL5 RL8 RL10 illegal checks
   assign ill = (!is_m && !m_en) || (is_u && !s_en);
   // RL6 RL9 RL11 virtual checks
   assign vir = (is_vs && !h_en) || (is_vu && !(h_en && s_en));

   // RL12 illegal first, then virtual, then execute
   assign dif.illegal = ill;
   assign dif.virt    = !ill && vir;
   assign dif.exec    = !ill && !vir;

   // RL7 invalidate demoted to flush
   // RL2 otherwise a true invalidate
   assign dif.flush = dif.exec && (dif.op == cmo_perm_pkg::OP_INVAL) &&
                      ((!is_m && m_inv == cmo_perm_pkg::INV_FLUSH) ||
                       (is_u && s_inv == cmo_perm_pkg::INV_FLUSH) ||
                       (is_vs && h_inv == cmo_perm_pkg::INV_FLUSH) ||
                       (is_vu && (h_inv == cmo_perm_pkg::INV_FLUSH ||
                                  s_inv == cmo_perm_pkg::INV_FLUSH)));
endmodule : cmo_decide
`default_nettype wire

/* File: tb/trap_sink.sv */
// Purpose: trap pipeline stand-in that takes every permission answer
// Assumes: answers are registered pulses on the core clock
// Notes:   counts answers and flags any mix of outcomes
`timescale 1ns/1ps
`default_nettype none
module trap_sink (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        rsp_valid,
   input  wire logic        rsp_illegal,
   input  wire logic        rsp_virtual,
   input  wire logic        rsp_exec,
   output var  logic [15:0] answered,
   output var  logic [15:0] bad_mix
);
   // answers taken by the pipeline
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         answered <= 16'h0000;
      end else if (rsp_valid) begin
         answered <= answered + 16'h0001;
      end
   end
   // one outcome only
   // a stray outcome outside a valid cycle would be taken as a trap
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bad_mix <= 16'h0000;
      end else if (rsp_valid !== ((rsp_illegal + rsp_virtual + rsp_exec) == 2'd1)) begin
         bad_mix <= bad_mix + 16'h0001;
      end else if (!rsp_valid && (rsp_illegal || rsp_virtual || rsp_exec)) begin
         bad_mix <= bad_mix + 16'h0001;
      end
   end
endmodule : trap_sink
`default_nettype wire

/* File: tb/cache_op_permission_check_bench.sv */
// Purpose: self-checking bench for cache-op permission checks
// Assumes: clock enable high except in the freeze scenario, one request every other cycle
// Notes:   expected outcomes come from a local reference function
`timescale 1ns/1ps
`default_nettype none
module cache_op_permission_check_bench;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        ce = 1'b1;
   logic        hyp_on = 1'b1;
   logic        csr_we = 1'b0;
   logic [1:0]  csr_sel = 2'h0;
   logic [63:0] csr_wdata = 64'h0000_0000_0000_0000;
   logic        req_valid = 1'b0;
   logic [1:0]  req_op = 2'h0;
   logic [2:0]  req_priv = 3'h0;
   logic [63:0] csr_rdata;
   logic        rsp_valid, rsp_illegal, rsp_virtual, rsp_exec, rsp_flush;
   logic [7:0]  disc_mgmt_blk, disc_zero_blk;
   logic [2:0]  disc_inv_ok;
   logic [15:0] answered, bad_mix;
   logic [2:0]  privs [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
   int          miscompares = 0;
   int          cmp_count = 0;
   int          sent = 0;

   cache_op_permission_check u_cache_op_permission_check (
      .clk(clk), .arst_n(arst_n), .ce(ce), .hyp_on(hyp_on), .csr_we(csr_we),
      .csr_sel(csr_sel), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
      .req_valid(req_valid), .req_op(req_op), .req_priv(req_priv),
      .rsp_valid(rsp_valid), .rsp_illegal(rsp_illegal), .rsp_virtual(rsp_virtual),
      .rsp_exec(rsp_exec), .rsp_flush(rsp_flush), .disc_mgmt_blk(disc_mgmt_blk),
      .disc_zero_blk(disc_zero_blk), .disc_inv_ok(disc_inv_ok));
   trap_sink u_trap_sink (
      .clk(clk), .arst_n(arst_n), .rsp_valid(rsp_valid), .rsp_illegal(rsp_illegal),
      .rsp_virtual(rsp_virtual), .rsp_exec(rsp_exec), .answered(answered), .bad_mix(bad_mix));

   // free-running core clock
   always #5 clk = ~clk;

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task automatic csr_write(input logic [1:0] sel, input logic [7:0] b);
      @(posedge clk);
      csr_we <= 1'b1;
      csr_sel <= sel;
      csr_wdata <= {56'h00_0000_0000_0000, b};
      @(posedge clk);
      csr_we <= 1'b0;
   endtask : csr_write

   task automatic csr_read(input logic [1:0] sel, input logic [7:0] b);
      @(posedge clk);
      csr_sel <= sel;
      @(posedge clk);
      #1;
      chk(csr_rdata, {56'h00_0000_0000_0000, b}, "register readback");
   endtask : csr_read

   // enable of one register for the given operation
   function automatic logic en(input logic [1:0] op, input logic [7:0] c);
      if (op == cmo_perm_pkg::OP_INVAL) return c[5:4] != 2'h0;
      if (op == cmo_perm_pkg::OP_ZERO) return c[7];
      return c[6];
   endfunction : en

   // outcome as {illegal, virtual, exec, flush}, illegal ahead of virtual
   function automatic logic [3:0] ref_rsp(input logic [1:0] op, input logic [2:0] p,
                                          input logic [7:0] m, input logic [7:0] s,
                                          input logic [7:0] h, input logic hy);
      logic not_m, u, vs, vu, fl;
      not_m = p != 3'h3;
      u = p == 3'h0;
      vs = hy && p == 3'h5;
      vu = hy && p == 3'h4;
      if ((not_m && !en(op, m)) || (u && !en(op, s))) return 4'h8;
      if ((vs && !en(op, h)) || (vu && !(en(op, h) && en(op, s)))) return 4'h4;
      fl = (not_m && m[5:4] == 2'h1) || (u && s[5:4] == 2'h1) || (vs && h[5:4] == 2'h1) ||
           (vu && (h[5:4] == 2'h1 || s[5:4] == 2'h1));
      return (op == cmo_perm_pkg::OP_INVAL && fl) ? 4'h3 : 4'h2;
   endfunction : ref_rsp

   task automatic do_req(input logic [1:0] op, input logic [2:0] p, input logic [3:0] exp);
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_priv <= p;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      sent++;
      chk({rsp_valid, rsp_illegal, rsp_virtual, rsp_exec, rsp_flush}, {1'b1, exp}, "answer");
   endtask : do_req

   task automatic t_reset;
      csr_read(cmo_perm_pkg::SEL_M, 8'h00); // reset traps
      csr_read(cmo_perm_pkg::SEL_S, 8'h00); // single supervisor copy
      csr_read(cmo_perm_pkg::SEL_H, 8'h00); // hypervisor copy
      chk({disc_mgmt_blk, disc_zero_blk, disc_inv_ok}, {8'h06, 8'h06, 3'h7}, "discovery");
      do_req(cmo_perm_pkg::OP_ZERO, cmo_perm_pkg::PRV_M, 4'h2); // machine never blocked
   endtask : t_reset

   task automatic t_reserved;
      csr_write(cmo_perm_pkg::SEL_M, 8'h10);
      csr_write(cmo_perm_pkg::SEL_M, 8'hE0);
      csr_read(cmo_perm_pkg::SEL_M, 8'hD0); // reserved keeps old field
      csr_write(2'h3, 8'hF0);
      csr_read(2'h3, 8'h00); // unmapped select
   endtask : t_reserved

   // four settings per register in the first n of the 64 combinations, each operation and privilege
   task automatic t_matrix(input logic hy, input int n);
      logic [7:0] f [3];
      logic [1:0] c;
      for (int i = 0; i < n; i++) begin
         for (int k = 0; k < 3; k++) begin
            c = 2'(i >> (2 * k));
            f[k] = {c[1], c[0], (c == 2'h2) ? 2'h3 : c, 4'h0};
            if (!disc_inv_ok[k]) begin
               f[k][5:4] = 2'h0;
            end
            csr_write(2'(k), f[k]);
         end
         csr_read(cmo_perm_pkg::SEL_S, f[1]); // field layout
         do_req(cmo_perm_pkg::OP_CLEAN, cmo_perm_pkg::PRV_M, 4'h2);
         for (int op = 0; op < 4; op++) begin
            for (int j = 0; j < 5; j++) begin
               do_req(2'(op), privs[j], ref_rsp(2'(op), privs[j], f[0], f[1], f[2], hy));
            end
         end
      end
   endtask : t_matrix

   // clock enable low freezes everything; a reset in mid-run clears the fields
   task automatic t_freeze;
      csr_write(cmo_perm_pkg::SEL_M, 8'h80);
      csr_write(cmo_perm_pkg::SEL_S, 8'hF0);
      // unlisted privilege code 2 is below machine
      do_req(cmo_perm_pkg::OP_ZERO, 3'h2, 4'h2);
      do_req(cmo_perm_pkg::OP_CLEAN, 3'h2, 4'h8);
      @(posedge clk);
      ce <= 1'b0;
      csr_we <= 1'b1;
      csr_wdata <= 64'h0000_0000_0000_0000;
      req_valid <= 1'b1;
      repeat (2) @(posedge clk);
      ce <= 1'b1;
      csr_we <= 1'b0;
      req_valid <= 1'b0;
      #1;
      chk(rsp_valid, 1'b0, "answer while frozen");
      csr_read(cmo_perm_pkg::SEL_S, 8'hF0); // frozen write dropped
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // the answer counter in the sink restarts with the reset
      sent = 0;
      csr_read(cmo_perm_pkg::SEL_S, 8'h00); // fields cleared by reset
   endtask : t_freeze

   task automatic t_hyp_off;
      @(posedge clk);
      hyp_on <= 1'b0;
      csr_write(cmo_perm_pkg::SEL_H, 8'hF0);
      csr_read(cmo_perm_pkg::SEL_H, 8'h00); // absent without hypervisor
      t_matrix(1'b0, 16); // no virtual faults
   endtask : t_hyp_off

   // watchdog at about five times the expected four thousand cycles
   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_reserved();
      t_freeze();
      t_matrix(1'b1, 64);
      t_hyp_off();
      repeat (2) @(posedge clk);
      chk(64'(answered), 64'(sent), "answers counted");
      chk(64'(bad_mix), 64'h0000_0000_0000_0000, "outcome mix");
      wrap_up();
   end
endmodule : cache_op_permission_check_bench
`default_nettype wire
